// ---- bench/pkidl_plat_model.sv ----
// Platform model granting package low-power permission.
// Assumes the bench sets the wanted grant and the answer latency.
`timescale 1ns/1ps
module pkidl_plat_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic grant_req,
  input wire logic allow_c6_req,
  input wire logic hold_req,
  input wire logic [3:0] lat,
  output logic plat_grant,
  output logic plat_allow_c6,
  output logic plat_hold
);
  logic [3:0] cnt_r;
  // Grant is slow to give, quick to withdraw
  always_ff @(posedge aclk) begin
    if (!aresetn || !grant_req) begin
      cnt_r <= 4'h0;
      plat_grant <= 1'b0;
    end else if (cnt_r >= lat) begin
      plat_grant <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    plat_allow_c6 <= aresetn & allow_c6_req;
    plat_hold <= aresetn & hold_req;
  end
endmodule

// ---- bench/pkidl_props.sv ----
// Checker for the package idle-state resolver, watching top ports only.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module pkidl_props #(
  parameter int NCORES = 2,
  parameter int NRANKS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [3*NCORES-1:0] core_state,
  input wire logic plat_grant,
  input wire logic plat_allow_c6,
  input wire pkidl_pkg::pkidl_brk_type brk,
  input wire logic [NCORES-1:0] brk_target,
  input wire logic mem_req_pending,
  input wire pkidl_pkg::pkidl_cstate_type pkg_state,
  input wire logic [NCORES-1:0] core_wake,
  input wire logic freq_low,
  input wire logic volt_low,
  input wire logic [NRANKS-1:0] rank_clock_enable,
  input wire logic [NRANKS-1:0] rank_cke_oe,
  input wire logic [NRANKS-1:0] rank_cs_oe
);
  logic any_c0;
  logic all_c6;
  always_comb begin
    any_c0 = 1'b0;
    all_c6 = 1'b1;
    for (int i = 0; i < NCORES; i++) begin
      any_c0 = any_c0 | (core_state[3*i +: 3] == 3'h0);
      all_c6 = all_c6 & (core_state[3*i +: 3] == 3'h4);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so no disable
  chk_cke_reset: assert property (disable iff (1'b0)
    !aresetn |=> rank_clock_enable == '0) else $error("cke high in reset");
  chk_cke_unpop: assert property (
    (rank_clock_enable & ~rank_cke_oe) == '0) else $error("cke on empty rank");
  chk_oe_reset: assert property (disable iff (1'b0)
    !aresetn |=> (rank_cke_oe & rank_cs_oe) == '1)
    else $error("rank pins undriven in reset");
  chk_c6_entry: assert property (
    pkg_state == pkidl_pkg::PKIDL_C6 && $changed(pkg_state)
    |-> $past(all_c6 && plat_grant && plat_allow_c6))
    else $error("c6 entered without cause");
  chk_lp_grant: assert property (
    pkg_state inside {pkidl_pkg::PKIDL_C3, pkidl_pkg::PKIDL_C6}
    && $changed(pkg_state) |-> $past(plat_grant))
    else $error("deep state without grant");
  chk_c0_any: assert property (
    clk_en && any_c0 |=> pkg_state == pkidl_pkg::PKIDL_C0)
    else $error("package not active with active core");
  chk_unmasked_brk: assert property (
    clk_en && brk.core_brk && !brk.masked |=> pkg_state == pkidl_pkg::PKIDL_C0)
    else $error("unmasked break left package idle");
  chk_wake_target: assert property (
    clk_en && brk.core_brk && pkg_state != pkidl_pkg::PKIDL_C0
    |=> core_wake == $past(brk_target)) else $error("wrong core woken");
  chk_volt_after: assert property (
    $rose(volt_low) |-> freq_low && $past(freq_low, 4))
    else $error("voltage dropped before clock");
  chk_sref_c6: assert property (
    $changed(pkg_state) && pkg_state == pkidl_pkg::PKIDL_C6 && !mem_req_pending
    |-> ##[1:4] rank_clock_enable == '0) else $error("no self-refresh in c6");
  cov_c6: cover property (pkg_state == pkidl_pkg::PKIDL_C6);
  cov_volt: cover property ($rose(volt_low));
  cov_wake: cover property (|core_wake);
endmodule

bind pkidl_top pkidl_props #(.NCORES(NCORES), .NRANKS(NRANKS)) i_props (
  .aclk, .aresetn, .clk_en, .core_state, .plat_grant, .plat_allow_c6, .brk,
  .brk_target, .mem_req_pending, .pkg_state, .core_wake, .freq_low,
  .volt_low, .rank_clock_enable, .rank_cke_oe, .rank_cs_oe);

// ---- bench/tb_top.sv ----
// Self-checking bench for the package idle-state resolver.
// Assumes pkidl_top with two cores and four ranks, platform model beside.
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] core_state = '0;
  logic [1:0] core_c1e_hint = '0;
  logic [1:0] core_halt = '0;
  logic [1:0] brk_target = '0;
  logic [2:0] brk3 = '0;
  logic grant_req = 1'b0, a6_req = 1'b0, hold_req = 1'b0;
  logic [3:0] lat = '0;
  logic plat_grant, plat_allow_c6, hold;
  pkidl_pkg::pkidl_brk_type brk;
  logic mem_req_pending = 1'b0, refresh_due = 1'b0;
  logic suspend_req = 1'b0, flush_done = 1'b0;
  logic [3:0] rank_idle = '0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pkidl_pkg::pkidl_cstate_type pkg_state, ex;
  logic [1:0] core_wake;
  logic freq_low, volt_low, cache_snoopable, precharge_all, refresh_go;
  logic flush_req;
  logic [3:0] rank_clock_enable, rank_cke_oe, rank_cs_oe;
  int n_errors = 0;
  int num_checks = 0;
  logic saw_c0, saw_pre, g, a;
  logic [31:0] rd;
  logic [1:0] rr, hh, ht;
  logic [2:0] c0, c1;
  logic [31:0] cfg [4] = '{32'h405, 32'h403, 32'h303, 32'h203};
  logic [7:0] rad [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rex [4] = '{32'h400, 32'hf, 32'h10, 32'h0};

  assign brk = {brk3, hold};
  always #5 aclk = ~aclk;

  pkidl_top #(.NCORES(2), .NRANKS(4)) i_dut (.aclk, .aresetn, .clk_en,
    .core_state, .core_c1e_hint, .core_halt, .plat_grant, .plat_allow_c6,
    .brk, .brk_target, .mem_req_pending, .refresh_due, .suspend_req,
    .flush_done, .rank_idle, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pkg_state, .core_wake, .freq_low, .volt_low, .cache_snoopable,
    .rank_clock_enable, .rank_cke_oe, .rank_cs_oe, .precharge_all,
    .refresh_go, .flush_req);
  pkidl_plat_model i_plat (.aclk, .aresetn, .grant_req,
    .allow_c6_req(a6_req), .hold_req, .lat, .plat_grant, .plat_allow_c6,
    .plat_hold(hold));

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_s(input pkidl_pkg::pkidl_cstate_type got,
                       input pkidl_pkg::pkidl_cstate_type exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t package state %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Runs up to n cycles; sel stops early on a chosen event
  task automatic cyc(input int n, input int sel);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      saw_c0 |= (pkg_state == pkidl_pkg::PKIDL_C0);
      saw_pre |= precharge_all;
      if ((sel == 1 && rank_clock_enable == 4'h0) || (sel == 2 && refresh_go)
          || (sel == 3 && flush_req)) break;
    end
  endtask
  task automatic pulse(input logic [2:0] b, input logic [1:0] t);
    brk3 <= b;
    brk_target <= t;
    @(posedge aclk);
    brk3 <= 3'h0;
    @(posedge aclk);
    chk_v(32'(core_wake), 32'(t));
  endtask
  function automatic pkidl_pkg::pkidl_cstate_type exp_pkg(input logic [5:0] c,
      input logic gr, input logic al, input logic e, input logic [2:0] lim);
    logic [2:0] m;
    m = (c[2:0] < c[5:3]) ? c[2:0] : c[5:3];
    if (m == 3'h0 || (m > 3'h2 && !gr)) return pkidl_pkg::PKIDL_C0;
    if (m > 3'h2 && lim > 3'h2) return (m == 3'h4 && al && lim == 3'h4) ?
      pkidl_pkg::PKIDL_C6 : pkidl_pkg::PKIDL_C3;
    return (e || m != 3'h1) ? pkidl_pkg::PKIDL_C1E : pkidl_pkg::PKIDL_C1;
  endfunction

  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(97316));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_v(32'(rank_clock_enable), 32'h0);
    chk_v(32'(rank_cke_oe), 32'hf);
    for (int k = 0; k < 4; k++) begin
      axr(rad[k]);
      chk_v(rd, rex[k]);
      chk_v(32'(rr), (k == 3) ? 32'h2 : 32'h0);
    end
    axw(8'h04, 32'h3);
    cyc(3, 0);
    chk_v(32'({rank_cke_oe, rank_cs_oe}), 32'h33);
    chk_v(32'(rank_clock_enable), 32'h0);
    for (int k = 0; k < 4; k++) begin
      axw(8'h00, cfg[k]);
      for (int j = 0; j < 30; j++) begin
        c0 = 3'($urandom_range(4));
        c1 = 3'($urandom_range(4));
        // Per-core enhanced state only exists with the option on
        if (!cfg[k][1] && c0 == 3'h2) c0 = 3'h1;
        if (!cfg[k][1] && c1 == 3'h2) c1 = 3'h1;
        g = cfg[k][10] ? 1'($urandom_range(1)) : 1'b1;
        a = 1'($urandom_range(1));
        core_state <= {c1, c0};
        hh = 2'($urandom);
        ht = 2'($urandom);
        core_c1e_hint <= hh;
        core_halt <= ht;
        grant_req <= g;
        a6_req <= a;
        lat <= 4'($urandom_range(3));
        cyc(8, 0);
        ex = exp_pkg({c1, c0}, g, a,
          cfg[k][1] | (&hh) | (cfg[k][2] & (&ht)), cfg[k][10:8]);
        chk_s(pkg_state, ex);
      end
    end
    axw(8'h00, 32'h403);
    core_state <= 6'o44;
    grant_req <= 1'b1;
    a6_req <= 1'b1;
    cyc(10, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C6);
    chk_v(32'(rank_clock_enable), 32'h0);
    chk_v(32'(cache_snoopable), 32'h1);
    a6_req <= 1'b0;
    saw_c0 = 1'b0;
    cyc(8, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C3);
    chk_v(32'(saw_c0), 32'h0);
    a6_req <= 1'b1;
    cyc(8, 0);
    pulse(3'b110, 2'b10);
    cyc(10, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C6);
    pulse(3'b001, 2'b00);
    cyc(10, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C6);
    core_state <= 6'o40;
    pulse(3'b100, 2'b01);
    cyc(4, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C0);
    chk_v(32'(rank_clock_enable), 32'h3);
    core_state <= 6'o44;
    mem_req_pending <= 1'b1;
    cyc(10, 0);
    chk_v(32'(rank_clock_enable), 32'h3);
    mem_req_pending <= 1'b0;
    cyc(10, 0);
    hold_req <= 1'b1;
    cyc(3, 0);
    pulse(3'b001, 2'b00);
    cyc(6, 0);
    chk_s(pkg_state, pkidl_pkg::PKIDL_C0);
    hold_req <= 1'b0;
    core_state <= 6'o00;
    rank_idle <= 4'hf;
    axw(8'h00, 32'h41b);
    saw_pre = 1'b0;
    cyc(80, 1);
    chk_v(32'(rank_clock_enable), 32'h0);
    chk_v(32'(saw_pre), 32'h1);
    refresh_due <= 1'b1;
    cyc(60, 2);
    chk_v(32'({refresh_go, rank_clock_enable}), 32'h13);
    refresh_due <= 1'b0;
    cyc(80, 1);
    chk_v(32'(rank_clock_enable), 32'h0);
    axw(8'h00, 32'h403);
    rank_idle <= 4'h0;
    suspend_req <= 1'b1;
    cyc(60, 3);
    chk_v(32'(flush_req), 32'h1);
    flush_done <= 1'b1;
    cyc(10, 0);
    chk_v(32'(rank_clock_enable), 32'h0);
    cyc(20, 0);
    chk_v(32'(rank_clock_enable), 32'h0);
    give_verdict();
  end
endmodule

// ---- hdl/pkidl_pkg.sv ----
// Package for the package idle-state resolver and DRAM power steering.
// Assumes one clock domain and an AXI4-Lite register slave in the top.
package pkidl_pkg;
  // Idle-state encodings, numerically ordered by depth
  typedef enum logic [2:0] {
    PKIDL_C0  = 3'h0,
    PKIDL_C1  = 3'h1,
    PKIDL_C1E = 3'h2,
    PKIDL_C3  = 3'h3,
    PKIDL_C6  = 3'h4
  } pkidl_cstate_type;

  // DRAM power modes reported in status
  typedef enum logic [2:0] {
    PKIDL_MEM_ACTIVE = 3'h0,
    PKIDL_MEM_PDOWN  = 3'h1,
    PKIDL_MEM_SREF   = 3'h2,
    PKIDL_MEM_REFUP  = 3'h3,
    PKIDL_MEM_FLUSH  = 3'h4,
    PKIDL_MEM_SUSP   = 3'h5
  } pkidl_mem_type;

  // Break event bundle
  typedef struct packed {
    logic core_brk;
    logic masked;
    logic mem_brk;
    logic plat_hold;
  } pkidl_brk_type;

  // Register byte offsets
  localparam logic [7:0] PKIDL_CTRL_OFS = 8'h00;
  localparam logic [7:0] PKIDL_POP_OFS = 8'h04;
  localparam logic [7:0] PKIDL_PDT_OFS = 8'h08;
  localparam logic [7:0] PKIDL_STAT_OFS = 8'h0c;

  // Control register fields
  localparam int PKIDL_CTRL_CKE_REL = 0;
  localparam int PKIDL_CTRL_C1E_EN = 1;
  localparam int PKIDL_CTRL_AUTO_PROMO = 2;
  localparam int PKIDL_CTRL_DPD_EN = 3;
  localparam int PKIDL_CTRL_PRECHG = 4;
  localparam int PKIDL_CTRL_LIMIT_LSB = 8;
  localparam int PKIDL_CTRL_LIMIT_W = 3;
  localparam logic [31:0] PKIDL_CTRL_RST = 32'h0000_0400;
  localparam logic [3:0] PKIDL_POP_RST = 4'hf;
  localparam logic [15:0] PKIDL_PDT_RST = 16'h0010;

  // Timing: ramp steps for enhanced halt clock then voltage drop
  localparam int PKIDL_FREQ_STEP_CYC = 4;
  localparam int PKIDL_PRECHG_CYC = 2;
  localparam logic [1:0] PKIDL_RESP_OKAY = 2'h0;
  localparam logic [1:0] PKIDL_RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/pkidl_top.sv ----
// Package idle-state resolver with DRAM clock-enable steering.
// Assumes synchronous inputs on aclk and an AXI4-Lite master.
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Package request is the shallowest idle state of all cores
// RULE_02 - Low-power package states need platform grant; cores may be deeper
// RULE_03 - DRAM goes to self-refresh in package states three and six
// RULE_04 - Low-power package states change directly, no pass through active
// RULE_05 - Break event exits low power and brings DRAM out of self-refresh
// RULE_06 - Core break wakes target core; unmasked makes core and package active
// RULE_07 - Masked core break re-enters the prior package state
// RULE_08 - Memory or snoop break returns to prior state unless platform holds
// RULE_09 - Enhanced halt on and all cores first state or deeper gives enhanced
// RULE_10 - Package stays active if any core active or no grant; code still enters first or enhanced first without grant
// RULE_11 - Plain first state no action; enhanced lowers clock then voltage
// RULE_12 - Enhanced first entry by hint, by package limit, or auto-promotion
// RULE_13 - No system notification on first or enhanced first entry
// RULE_14 - State three when all cores three+ with grant, or six capped
// RULE_15 - State six only when all cores six and granted; cache stays snoopable
// RULE_16 - Unpopulated ranks get no chip-select or clock-enable drive
// RULE_17 - All rows treated populated after reset until configured otherwise
// RULE_18 - All four clock enables low in reset until firmware releases them
// RULE_19 - Suspend flushes pending cycles, self-refreshes ranks, holds CKE low
// RULE_20 - Self-refresh in three/six only with no requests, else rank power-down
// RULE_21 - Power-down mode selectable: active or precharge closing pages first
// RULE_22 - Dynamic power-down wakes all ranks for refresh, drops them after
module pkidl_top #(
  parameter int NCORES = 2,
  parameter int NRANKS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [3*NCORES-1:0] core_state,
  input wire logic [NCORES-1:0] core_c1e_hint,
  input wire logic [NCORES-1:0] core_halt,
  input wire logic plat_grant,
  input wire logic plat_allow_c6,
  input wire pkidl_pkg::pkidl_brk_type brk,
  input wire logic [NCORES-1:0] brk_target,
  input wire logic mem_req_pending,
  input wire logic refresh_due,
  input wire logic suspend_req,
  input wire logic flush_done,
  input wire logic [NRANKS-1:0] rank_idle,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pkidl_pkg::pkidl_cstate_type pkg_state,
  output logic [NCORES-1:0] core_wake,
  output logic freq_low,
  output logic volt_low,
  output logic cache_snoopable,
  output logic [NRANKS-1:0] rank_clock_enable,
  output logic [NRANKS-1:0] rank_cke_oe,
  output logic [NRANKS-1:0] rank_cs_oe,
  output logic precharge_all,
  output logic refresh_go,
  output logic flush_req
);
  pkidl_pkg::pkidl_cstate_type req_st, tgt_st, prior_r, pkg_r;
  pkidl_pkg::pkidl_mem_type mem_r;
  logic [31:0] ctrl_r;
  logic [3:0] pop_r;
  logic [15:0] pdt_r;
  logic [15:0] idle_cnt_r [NRANKS];
  logic [NRANKS-1:0] pd_r;
  logic brk_hold_r;
  logic [3:0] ramp_r;
  logic [1:0] prech_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_r;
  logic [31:0] w_r;
  logic [3:0] ws_r;
  logic [2:0] limit;

  // Depth order of idle states; enhanced first counts as first
  function automatic logic [2:0] depth(input logic [2:0] s);
    depth = (s == 3'h2) ? 3'h1 : s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  assign limit = ctrl_r[pkidl_pkg::PKIDL_CTRL_LIMIT_LSB +:
                        pkidl_pkg::PKIDL_CTRL_LIMIT_W];

  // Request resolution
  always_comb begin
    logic [2:0] mn;
    logic all_hint, all_halt;
    mn = 3'h4;
    all_hint = 1'b1;
    all_halt = 1'b1;
    for (int i = 0; i < NCORES; i++) begin
      if (depth(core_state[3*i +: 3]) < mn) begin // [RULE_01]
        mn = depth(core_state[3*i +: 3]);
      end
      all_hint = all_hint & core_c1e_hint[i];
      all_halt = all_halt & core_halt[i];
    end
    req_st = pkidl_pkg::pkidl_cstate_type'(mn);
    tgt_st = req_st;
    if (req_st == pkidl_pkg::PKIDL_C0) begin
      tgt_st = pkidl_pkg::PKIDL_C0; // [RULE_10]
    end else if (req_st == pkidl_pkg::PKIDL_C1) begin
      // Enhanced entry by option, by hint or by auto-promotion
      if (ctrl_r[pkidl_pkg::PKIDL_CTRL_C1E_EN] || all_hint ||
          (all_halt && ctrl_r[pkidl_pkg::PKIDL_CTRL_AUTO_PROMO])) begin
        tgt_st = pkidl_pkg::PKIDL_C1E; // [RULE_09] [RULE_12]
      end else begin
        tgt_st = pkidl_pkg::PKIDL_C1;
      end
    end else if (!plat_grant) begin
      tgt_st = pkidl_pkg::PKIDL_C0; // [RULE_02] [RULE_10]
    end else if (limit <= 3'h2) begin
      tgt_st = pkidl_pkg::PKIDL_C1E; // [RULE_12]
    end else if (req_st == pkidl_pkg::PKIDL_C6 &&
                 (!plat_allow_c6 || limit == 3'h3)) begin
      tgt_st = pkidl_pkg::PKIDL_C3; // [RULE_14]
    end else begin
      tgt_st = req_st; // [RULE_14] [RULE_15]
    end
  end

  // Package state; direct moves between low states allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkg_r <= pkidl_pkg::PKIDL_C0;
      prior_r <= pkidl_pkg::PKIDL_C0;
      brk_hold_r <= 1'b0;
      core_wake <= '0;
    end else if (clk_en) begin
      core_wake <= '0;
      if (brk.core_brk && pkg_r != pkidl_pkg::PKIDL_C0) begin
        core_wake <= brk_target; // [RULE_06]
        if (!brk.masked) begin
          pkg_r <= pkidl_pkg::PKIDL_C0; // [RULE_06]
        end else begin
          prior_r <= pkg_r;
          brk_hold_r <= 1'b1; // [RULE_07]
          pkg_r <= pkidl_pkg::PKIDL_C0;
        end
      end else if (brk.mem_brk && pkg_r != pkidl_pkg::PKIDL_C0) begin
        prior_r <= pkg_r;
        pkg_r <= pkidl_pkg::PKIDL_C0; // [RULE_05]
        brk_hold_r <= !brk.plat_hold; // [RULE_08]
      end else if (brk_hold_r) begin
        brk_hold_r <= 1'b0;
        if (tgt_st != pkidl_pkg::PKIDL_C0) begin
          pkg_r <= prior_r; // [RULE_07] [RULE_08]
        end
      end else if (!brk.plat_hold || tgt_st == pkidl_pkg::PKIDL_C0) begin
        pkg_r <= tgt_st; // [RULE_04]
      end
    end
  end

  // Enhanced halt: clock first, voltage after a ramp; no system message
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_low <= 1'b0;
      volt_low <= 1'b0;
      ramp_r <= '0;
    end else if (clk_en) begin
      if (pkg_r == pkidl_pkg::PKIDL_C1E) begin
        freq_low <= 1'b1; // [RULE_11] [RULE_13]
        if (ramp_r == 4'(pkidl_pkg::PKIDL_FREQ_STEP_CYC)) begin
          volt_low <= 1'b1; // [RULE_11]
        end else begin
          ramp_r <= ramp_r + 4'h1;
        end
      end else begin
        freq_low <= 1'b0;
        volt_low <= 1'b0;
        ramp_r <= '0;
      end
      cache_snoopable <= 1'b1; // [RULE_14] [RULE_15]
    end
  end

  // Per-rank idle counters for dynamic power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_r <= '0;
      for (int i = 0; i < NRANKS; i++) begin
        idle_cnt_r[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NRANKS; i++) begin
        if (!rank_idle[i] || refresh_due ||
            !ctrl_r[pkidl_pkg::PKIDL_CTRL_DPD_EN]) begin
          idle_cnt_r[i] <= '0;
          pd_r[i] <= 1'b0; // [RULE_22]
        end else if (idle_cnt_r[i] == pdt_r) begin
          pd_r[i] <= 1'b1; // [RULE_20]
        end else begin
          idle_cnt_r[i] <= idle_cnt_r[i] + 16'h1;
        end
      end
    end
  end

  // Memory mode sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE;
      flush_req <= 1'b0;
      refresh_go <= 1'b0;
      precharge_all <= 1'b0;
      prech_r <= '0;
    end else if (clk_en) begin
      refresh_go <= 1'b0;
      precharge_all <= 1'b0;
      case (mem_r)
        pkidl_pkg::PKIDL_MEM_ACTIVE: begin
          if (suspend_req) begin
            flush_req <= 1'b1; // [RULE_19]
            mem_r <= pkidl_pkg::PKIDL_MEM_FLUSH;
          end else if ((pkg_r == pkidl_pkg::PKIDL_C3 ||
                        pkg_r == pkidl_pkg::PKIDL_C6) &&
                       !mem_req_pending) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_SREF; // [RULE_03] [RULE_20]
          end else if (refresh_due &&
                       ctrl_r[pkidl_pkg::PKIDL_CTRL_DPD_EN]) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_REFUP; // [RULE_22]
          end else if (|pd_r) begin
            if (ctrl_r[pkidl_pkg::PKIDL_CTRL_PRECHG] &&
                prech_r != 2'(pkidl_pkg::PKIDL_PRECHG_CYC)) begin
              precharge_all <= 1'b1; // [RULE_21]
              prech_r <= prech_r + 2'h1;
            end else begin
              mem_r <= pkidl_pkg::PKIDL_MEM_PDOWN;
            end
          end
        end
        pkidl_pkg::PKIDL_MEM_PDOWN: begin
          prech_r <= '0;
          if (suspend_req || ~|pd_r || refresh_due ||
              ((pkg_r == pkidl_pkg::PKIDL_C3 ||
                pkg_r == pkidl_pkg::PKIDL_C6) && !mem_req_pending)) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE;
          end
        end
        pkidl_pkg::PKIDL_MEM_SREF: begin
          if (suspend_req) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_SUSP;
          end else if ((pkg_r != pkidl_pkg::PKIDL_C3 &&
                        pkg_r != pkidl_pkg::PKIDL_C6) ||
                       mem_req_pending) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE; // [RULE_05]
          end
        end
        pkidl_pkg::PKIDL_MEM_REFUP: begin
          refresh_go <= 1'b1; // [RULE_22]
          mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE;
        end
        pkidl_pkg::PKIDL_MEM_FLUSH: begin
          if (flush_done) begin
            flush_req <= 1'b0;
            mem_r <= pkidl_pkg::PKIDL_MEM_SUSP; // [RULE_19]
          end
        end
        pkidl_pkg::PKIDL_MEM_SUSP: begin
          if (!suspend_req) begin
            mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE;
          end
        end
        default: mem_r <= pkidl_pkg::PKIDL_MEM_ACTIVE;
      endcase
    end
  end

  // Clock enable pins; held low until firmware release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rank_clock_enable <= '0; // [RULE_18]
      rank_cke_oe <= '1; // [RULE_17]
      rank_cs_oe <= '1;
    end else if (clk_en) begin
      rank_cke_oe <= pop_r[NRANKS-1:0]; // [RULE_16]
      rank_cs_oe <= pop_r[NRANKS-1:0]; // [RULE_16]
      for (int i = 0; i < NRANKS; i++) begin
        rank_clock_enable[i] <= ctrl_r[pkidl_pkg::PKIDL_CTRL_CKE_REL] &&
          pop_r[i] && mem_r != pkidl_pkg::PKIDL_MEM_SREF &&
          mem_r != pkidl_pkg::PKIDL_MEM_SUSP &&
          !(mem_r == pkidl_pkg::PKIDL_MEM_PDOWN && pd_r[i]); // [RULE_18]
      end
    end
  end

  // AXI4-Lite write channel; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= '0;
      w_r <= '0;
      ws_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pkidl_pkg::PKIDL_RESP_OKAY;
      ctrl_r <= pkidl_pkg::PKIDL_CTRL_RST;
      pop_r <= pkidl_pkg::PKIDL_POP_RST; // [RULE_17]
      pdt_r <= pkidl_pkg::PKIDL_PDT_RST;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= pkidl_pkg::PKIDL_RESP_OKAY;
        case (aw_r)
          pkidl_pkg::PKIDL_CTRL_OFS: ctrl_r <= merge(ctrl_r, w_r, ws_r);
          pkidl_pkg::PKIDL_POP_OFS: pop_r <= 4'(merge({28'h0, pop_r}, w_r,
                                                      ws_r));
          pkidl_pkg::PKIDL_PDT_OFS: pdt_r <= 16'(merge({16'h0, pdt_r}, w_r,
                                                       ws_r));
          pkidl_pkg::PKIDL_STAT_OFS: s_axi_bresp <= pkidl_pkg::PKIDL_RESP_OKAY;
          default: s_axi_bresp <= pkidl_pkg::PKIDL_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pkidl_pkg::PKIDL_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pkidl_pkg::PKIDL_RESP_OKAY;
        case (s_axi_araddr)
          pkidl_pkg::PKIDL_CTRL_OFS: s_axi_rdata <= ctrl_r;
          pkidl_pkg::PKIDL_POP_OFS: s_axi_rdata <= {28'h0, pop_r};
          pkidl_pkg::PKIDL_PDT_OFS: s_axi_rdata <= {16'h0, pdt_r};
          pkidl_pkg::PKIDL_STAT_OFS: s_axi_rdata <= {16'h0,
            4'h0, pd_r[3:0], 1'b0, mem_r, 1'b0, pkg_r};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= pkidl_pkg::PKIDL_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign pkg_state = pkg_r;
endmodule
